// ### common/ucd_defs.svh
// Constants of the channel command decoder: offsets, codes, field values and widths.
// Assumes inclusion by bare name from the package and the design modules.
//
// How it works
// - Command low nibble only switches that channel's transmitter and receiver.
// - Codes 1 to B hit the written channel only; C and D act chip-wide, through channel A only.
// - Reset-pointer command points the channel back at its first mode register.
// - Any first mode register access moves the pointer to the second one.
// - Receiver reset reinitialises and disables the receiver and flushes its queue.
// - Transmitter reset reinitialises the transmitter and drives the line high.
// - Error reset clears overrun, and in block error mode also break, parity and framing status flags.
// - Block error mode: raised error flags stay set until error reset.
// - Character error mode: parity, framing, break describe the head character only.
// - Overrun is always sticky; only error reset clears it.
// - Break-change reset clears the channel's pending break-change interrupt bit.
// - Start break holds the line low; transmitter must be enabled.
// - From an idle transmitter the break starts within two bit periods.
// - With characters pending the break waits for transmitter empty.
// - Stop break: line high within two bit periods, then one idle bit.
// - Two codes set and clear the receive rate-generator extend bit.
// - Two codes set and clear the transmit rate-generator extend bit.
// - Standby through channel A powers down chip; reset or active restores.
`ifndef UCD_DEFS_SVH
`define UCD_DEFS_SVH

`define UCD_AW 5
`define UCD_DW 8
`define UCD_OFS_MODE_A 5'h00
`define UCD_OFS_STAT_A 5'h01
`define UCD_OFS_CMD_A 5'h02
`define UCD_OFS_MODE_B 5'h08
`define UCD_OFS_STAT_B 5'h09
`define UCD_OFS_CMD_B 5'h0A
`define UCD_OFS_IRQ_STAT 5'h10
`define UCD_OFS_IRQ_MASK 5'h11
`define UCD_OFS_CHIP_CTL 5'h12

`define UCD_CMD_RST_PTR 4'h1
`define UCD_CMD_RST_RX 4'h2
`define UCD_CMD_RST_TX 4'h3
`define UCD_CMD_RST_ERR 4'h4
`define UCD_CMD_RST_BRK 4'h5
`define UCD_CMD_BRK_START 4'h6
`define UCD_CMD_BRK_STOP 4'h7
`define UCD_CMD_RX_EXT_SET 4'h8
`define UCD_CMD_RX_EXT_CLR 4'h9
`define UCD_CMD_TX_EXT_SET 4'hA
`define UCD_CMD_TX_EXT_CLR 4'hB
`define UCD_CMD_STANDBY 4'hC
`define UCD_CMD_ACTIVE 4'hD

`define UCD_EN_ON 2'h1
`define UCD_EN_OFF 2'h2
`define UCD_IRQ_W 4
`define UCD_IRQ_ZERO 4'h0
`define UCD_BYTE_ZERO 8'h00

`endif

// ### common/ucd_pkg.sv
// Types shared by the command decoder modules.
// Assumes ucd_defs.svh is on the include path.
`include "ucd_defs.svh"

package ucd_pkg;

    // Decoded command pulses of one write
    typedef struct packed {
        logic tx_on;
        logic tx_off;
        logic rx_on;
        logic rx_off;
        logic rst_ptr;
        logic rst_rx;
        logic rst_tx;
        logic rst_err;
        logic rst_brk;
        logic brk_start;
        logic brk_stop;
        logic rx_ext_set;
        logic rx_ext_clr;
        logic tx_ext_set;
        logic tx_ext_clr;
        logic standby;
        logic active;
    } ucd_cmd_t;

    // Per-channel inputs from the serial datapath
    typedef struct packed {
        logic pe_ev;
        logic fe_ev;
        logic rb_ev;
        logic oe_ev;
        logic head_pe;
        logic head_fe;
        logic head_rb;
        logic brk_chg_ev;
        logic tx_empty_condition;
        logic bit_tick;
        logic tx_serial;
    } ucd_chan_in_t;

    // Per-channel outputs towards the serial datapath
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic rx_reset;
        logic tx_reset;
        logic mode_reg_pointer;
        logic rx_ext;
        logic tx_ext;
        logic serial_tx_output;
        logic tx_start_ok;
        logic brk_chg_pend;
    } ucd_chan_out_t;

    typedef enum logic [2:0] {
        BK_IDLE, BK_WAIT_EMPTY, BK_ALIGN, BK_LOW, BK_RELEASE, BK_MARK
    } ucd_brk_t;

    typedef struct packed {
        ucd_chan_out_t out;
        logic received_break_flag;
        logic framing_error_flag;
        logic parity_error_flag;
        logic oe;
        ucd_brk_t brk;
    } ucd_chan_st_t;

    typedef struct packed {
        logic [`UCD_IRQ_W-1:0] irq_stat;
        logic [`UCD_IRQ_W-1:0] irq_mask;
        logic [1:0] err_block;
        logic standby;
        logic irq;
        logic [`UCD_DW-1:0] rdata;
    } ucd_top_st_t;

endpackage : ucd_pkg

// ### core/ucd_cmd_dec.sv
// Decodes one command byte into command pulses.
// Assumes a one-cycle write strobe; chip-wide codes honoured for channel A only.
`timescale 1ns/1ps
`default_nettype none
`include "ucd_defs.svh"

module ucd_cmd_dec (
    input wire logic wr, // Command write strobe
    input wire logic [`UCD_DW-1:0] data, // Command byte
    input wire logic is_chan_a, // High for channel A
    output ucd_pkg::ucd_cmd_t cmd // Decoded pulses
);

    logic [3:0] code;
    assign code = data[7:4];

    always_comb begin
        cmd = '0;
        if (wr) begin
            cmd.tx_on = (data[1:0] == `UCD_EN_ON);
            cmd.tx_off = (data[1:0] == `UCD_EN_OFF);
            cmd.rx_on = (data[3:2] == `UCD_EN_ON);
            cmd.rx_off = (data[3:2] == `UCD_EN_OFF);
            case (code)
                `UCD_CMD_RST_PTR: cmd.rst_ptr = 1'b1;
                `UCD_CMD_RST_RX: cmd.rst_rx = 1'b1;
                `UCD_CMD_RST_TX: cmd.rst_tx = 1'b1;
                `UCD_CMD_RST_ERR: cmd.rst_err = 1'b1;
                `UCD_CMD_RST_BRK: cmd.rst_brk = 1'b1;
                `UCD_CMD_BRK_START: cmd.brk_start = 1'b1;
                `UCD_CMD_BRK_STOP: cmd.brk_stop = 1'b1;
                `UCD_CMD_RX_EXT_SET: cmd.rx_ext_set = 1'b1;
                `UCD_CMD_RX_EXT_CLR: cmd.rx_ext_clr = 1'b1;
                `UCD_CMD_TX_EXT_SET: cmd.tx_ext_set = 1'b1;
                `UCD_CMD_TX_EXT_CLR: cmd.tx_ext_clr = 1'b1;
                `UCD_CMD_STANDBY: cmd.standby = is_chan_a;
                `UCD_CMD_ACTIVE: cmd.active = is_chan_a;
                default: ;
            endcase
        end
    end

endmodule : ucd_cmd_dec
`default_nettype wire

// ### core/ucd_top.sv
// Two-channel command register decoder with status, break control and interrupt.
// Assumes a synchronous host port and datapath inputs synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ucd_defs.svh"

module ucd_top (
    input wire logic ref_clk, // Device clock
    input wire logic rst, // Asynchronous reset, high
    input wire logic [`UCD_AW-1:0] addr, // Register address
    input wire logic [`UCD_DW-1:0] wdata, // Write data
    input wire logic wr_stb, // Write strobe
    input wire logic rd_stb, // Read strobe
    input wire ucd_pkg::ucd_chan_in_t [1:0] chan_in, // Datapath inputs, index 0 is A
    output logic [`UCD_DW-1:0] rdata, // Read data, cycle after strobe
    output ucd_pkg::ucd_chan_out_t [1:0] chan_out, // Datapath controls
    output logic standby, // Chip powered down
    output logic irq // Level interrupt
);

    // ------------------------------------------------------------
    // Top state
    // ------------------------------------------------------------
    ucd_pkg::ucd_top_st_t st_ff;
    ucd_pkg::ucd_top_st_t nxt_st;
    ucd_pkg::ucd_cmd_t [1:0] cmd;
    ucd_pkg::ucd_chan_st_t [1:0] ch_st;
    logic [1:0] chip_standby_req;
    logic [1:0] chip_active_req;
    logic [1:0] err_ev;
    logic [1:0] brk_ev;

    assign rdata = st_ff.rdata;
    assign standby = st_ff.standby;
    assign irq = st_ff.irq;

    // ------------------------------------------------------------
    // Per-channel logic
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_chan
            ucd_pkg::ucd_chan_st_t c_ff;
            ucd_pkg::ucd_chan_st_t nxt_c;
            logic cmd_wr;
            logic mode_acc;
            logic block_mode;
            ucd_pkg::ucd_chan_in_t ci;
            ucd_pkg::ucd_cmd_t cc;

            assign ci = chan_in[g];
            assign cc = cmd[g];
            assign block_mode = st_ff.err_block[g];
            assign cmd_wr = wr_stb &&
                (addr == ((g == 0) ? `UCD_OFS_CMD_A : `UCD_OFS_CMD_B));
            assign mode_acc = (wr_stb || rd_stb) &&
                (addr == ((g == 0) ? `UCD_OFS_MODE_A : `UCD_OFS_MODE_B));

            ucd_cmd_dec u_dec (
                .wr(cmd_wr),
                .data(wdata),
                .is_chan_a(g == 0),
                .cmd(cmd[g])
            );

            assign chip_standby_req[g] = cc.standby;
            assign chip_active_req[g] = cc.active;
            assign err_ev[g] = ci.pe_ev | ci.fe_ev | ci.rb_ev | ci.oe_ev;
            assign brk_ev[g] = ci.brk_chg_ev;
            assign chan_out[g] = c_ff.out;
            assign ch_st[g] = c_ff;

            always_comb begin
                nxt_c = c_ff;
                nxt_c.out.rx_reset = 1'b0;
                nxt_c.out.tx_reset = 1'b0;

                if (cc.tx_on) begin
                    nxt_c.out.tx_enable = 1'b1;
                end else if (cc.tx_off) begin
                    nxt_c.out.tx_enable = 1'b0;
                end
                if (cc.rx_on) begin
                    nxt_c.out.rx_enable = 1'b1;
                end else if (cc.rx_off) begin
                    nxt_c.out.rx_enable = 1'b0;
                end

                if (mode_acc) begin
                    nxt_c.out.mode_reg_pointer = 1'b1;
                end
                if (cc.rst_ptr) begin
                    nxt_c.out.mode_reg_pointer = 1'b0;
                end

                if (cc.rst_rx) begin
                    nxt_c.out.rx_enable = 1'b0;
                    nxt_c.out.rx_reset = 1'b1;
                end

                if (cc.rx_ext_set) begin
                    nxt_c.out.rx_ext = 1'b1;
                end else if (cc.rx_ext_clr) begin
                    nxt_c.out.rx_ext = 1'b0;
                end
                if (cc.tx_ext_set) begin
                    nxt_c.out.tx_ext = 1'b1;
                end else if (cc.tx_ext_clr) begin
                    nxt_c.out.tx_ext = 1'b0;
                end

                if (block_mode) begin
                    if (cc.rst_err) begin
                        nxt_c.parity_error_flag = 1'b0;
                        nxt_c.framing_error_flag = 1'b0;
                        nxt_c.received_break_flag = 1'b0;
                    end
                    nxt_c.parity_error_flag = nxt_c.parity_error_flag | ci.pe_ev;
                    nxt_c.framing_error_flag = nxt_c.framing_error_flag | ci.fe_ev;
                    nxt_c.received_break_flag = nxt_c.received_break_flag | ci.rb_ev;
                end else begin
                    nxt_c.parity_error_flag = ci.head_pe;
                    nxt_c.framing_error_flag = ci.head_fe;
                    nxt_c.received_break_flag = ci.head_rb;
                end
                if (cc.rst_err) begin
                    nxt_c.oe = 1'b0;
                end
                nxt_c.oe = nxt_c.oe | ci.oe_ev;

                if (cc.rst_brk) begin
                    nxt_c.out.brk_chg_pend = 1'b0;
                end
                nxt_c.out.brk_chg_pend = nxt_c.out.brk_chg_pend | ci.brk_chg_ev;

                // Break sequencer
                case (c_ff.brk)
                    ucd_pkg::BK_IDLE: begin
                        if (cc.brk_start && c_ff.out.tx_enable) begin
                            nxt_c.brk = ci.tx_empty_condition ?
                                ucd_pkg::BK_ALIGN : ucd_pkg::BK_WAIT_EMPTY;
                        end
                    end
                    ucd_pkg::BK_WAIT_EMPTY: begin
                        if (cc.brk_stop) begin
                            nxt_c.brk = ucd_pkg::BK_IDLE;
                        end else if (ci.tx_empty_condition) begin
                            nxt_c.brk = ucd_pkg::BK_ALIGN;
                        end
                    end
                    ucd_pkg::BK_ALIGN: begin
                        if (cc.brk_stop) begin
                            nxt_c.brk = ucd_pkg::BK_IDLE;
                        end else if (ci.bit_tick) begin
                            nxt_c.brk = ucd_pkg::BK_LOW;
                        end
                    end
                    ucd_pkg::BK_LOW: begin
                        if (cc.brk_stop) begin
                            nxt_c.brk = ucd_pkg::BK_RELEASE;
                        end
                    end
                    ucd_pkg::BK_RELEASE: begin
                        if (ci.bit_tick) begin
                            nxt_c.brk = ucd_pkg::BK_MARK;
                        end
                    end
                    ucd_pkg::BK_MARK: begin
                        if (ci.bit_tick) begin
                            nxt_c.brk = ucd_pkg::BK_IDLE;
                        end
                    end
                    default: begin
                        nxt_c.brk = ucd_pkg::BK_IDLE;
                    end
                endcase

                if (cc.rst_tx) begin
                    nxt_c.out.tx_enable = 1'b0;
                    nxt_c.out.tx_reset = 1'b1;
                    nxt_c.brk = ucd_pkg::BK_IDLE;
                end

                if (st_ff.standby || chip_standby_req[0]) begin
                    nxt_c.out.tx_enable = 1'b0;
                    nxt_c.out.rx_enable = 1'b0;
                end

                nxt_c.out.tx_start_ok = (nxt_c.brk == ucd_pkg::BK_IDLE) ||
                    (nxt_c.brk == ucd_pkg::BK_WAIT_EMPTY);
                if ((nxt_c.brk == ucd_pkg::BK_LOW) ||
                    (nxt_c.brk == ucd_pkg::BK_RELEASE)) begin
                    nxt_c.out.serial_tx_output = 1'b0;
                end else if ((nxt_c.brk != ucd_pkg::BK_IDLE) &&
                    (nxt_c.brk != ucd_pkg::BK_WAIT_EMPTY)) begin
                    nxt_c.out.serial_tx_output = 1'b1;
                end else if (cc.rst_tx || !nxt_c.out.tx_enable) begin
                    nxt_c.out.serial_tx_output = 1'b1;
                end else begin
                    nxt_c.out.serial_tx_output = ci.tx_serial;
                end
            end

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    c_ff <= '0;
                    c_ff.brk <= ucd_pkg::BK_IDLE;
                    c_ff.out.serial_tx_output <= 1'b1;
                    c_ff.out.tx_start_ok <= 1'b1;
                end else begin
                    c_ff <= nxt_c;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Register file, interrupt and chip mode
    // ------------------------------------------------------------
    function automatic logic [`UCD_DW-1:0] stat_byte(input ucd_pkg::ucd_chan_st_t c,
                                                     input logic empty);
        stat_byte = {c.received_break_flag, c.framing_error_flag, c.parity_error_flag,
                     c.oe, empty, 3'h0};
    endfunction : stat_byte

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = `UCD_BYTE_ZERO;

        // Interrupt status, write one to clear, set wins
        if (wr_stb && (addr == `UCD_OFS_IRQ_STAT)) begin
            nxt_st.irq_stat = st_ff.irq_stat & ~wdata[`UCD_IRQ_W-1:0];
        end
        if (cmd[0].rst_brk) begin
            nxt_st.irq_stat[0] = 1'b0;
        end
        if (cmd[1].rst_brk) begin
            nxt_st.irq_stat[1] = 1'b0;
        end
        nxt_st.irq_stat = nxt_st.irq_stat | {err_ev, brk_ev};

        if (wr_stb && (addr == `UCD_OFS_IRQ_MASK)) begin
            nxt_st.irq_mask = wdata[`UCD_IRQ_W-1:0];
        end
        if (wr_stb && (addr == `UCD_OFS_CHIP_CTL)) begin
            nxt_st.err_block = wdata[2:1];
        end

        // standby and active via channel A
        if (chip_standby_req[0]) begin
            nxt_st.standby = 1'b1;
        end else if (chip_active_req[0]) begin
            nxt_st.standby = 1'b0;
        end

        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

        if (rd_stb) begin
            case (addr)
                `UCD_OFS_STAT_A: nxt_st.rdata = stat_byte(ch_st[0],
                                                          chan_in[0].tx_empty_condition);
                `UCD_OFS_STAT_B: nxt_st.rdata = stat_byte(ch_st[1],
                                                          chan_in[1].tx_empty_condition);
                `UCD_OFS_IRQ_STAT: nxt_st.rdata = {4'h0, st_ff.irq_stat};
                `UCD_OFS_IRQ_MASK: nxt_st.rdata = {4'h0, st_ff.irq_mask};
                `UCD_OFS_CHIP_CTL: nxt_st.rdata = {3'h0,
                                                   ch_st[1].out.mode_reg_pointer,
                                                   ch_st[0].out.mode_reg_pointer,
                                                   st_ff.err_block, st_ff.standby};
                default: nxt_st.rdata = `UCD_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : ucd_top
`default_nettype wire

// ### test/ucd_dp_model.sv
// Serial datapath stand-in for channel A: bit ticks and a shifter.
// Assumes ucd_top drives the enable and the start permission.
`timescale 1ns/1ps
`default_nettype none

module ucd_dp_model (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire logic go, // Load one character
    input wire logic tx_enable, // Transmitter on
    input wire logic tx_start_ok, // Start allowed
    output logic bit_tick, // Bit period pulse
    output logic tx_empty_condition, // Shifter empty
    output logic tx_serial // Shifter data
);
    logic [1:0] div_ff;
    logic [3:0] bits_ff;
    // ----------------------------------------
    // Shifter, ten bits of four cycles each
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_ff <= 2'h0;
            bits_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 2'h1;
            if (go && tx_enable && tx_start_ok && bits_ff == 4'h0) begin
                bits_ff <= 4'hA;
            end else if (bit_tick && bits_ff != 4'h0) begin
                bits_ff <= bits_ff - 4'h1;
            end
        end
    end
    assign bit_tick = div_ff == 2'h3;
    assign tx_empty_condition = bits_ff == 4'h0;
    assign tx_serial = bits_ff != 4'hA;
endmodule : ucd_dp_model
`default_nettype wire

// ### test/ucd_checker.sv
// Port assertions of the command decoder.
// Assumes binding onto ucd_top.
`timescale 1ns/1ps
`default_nettype none
`include "ucd_defs.svh"

module ucd_checker (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire logic [`UCD_AW-1:0] addr, // Address
    input wire logic [`UCD_DW-1:0] wdata, // Write data
    input wire logic wr_stb, // Write
    input wire logic rd_stb, // Read
    input wire ucd_pkg::ucd_chan_in_t [1:0] chan_in, // Datapath in
    input wire logic [`UCD_DW-1:0] rdata, // Read data
    input wire ucd_pkg::ucd_chan_out_t [1:0] chan_out, // Datapath out
    input wire logic standby, // Standby
    input wire logic irq // Interrupt
);
    logic wa;
    logic wb;
    logic [3:0] op;
    assign wa = wr_stb && addr == `UCD_OFS_CMD_A;
    assign wb = wr_stb && addr == `UCD_OFS_CMD_B;
    assign op = wdata[7:4];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Command effects
    // ----------------------------------------
    a_tx_on_cmd: assert property (wa && op == 4'h0 && wdata[1:0] == 2'h1 && !standby
        |=> chan_out[0].tx_enable) else $error("tx enable missed");
    a_rx_off_cmd: assert property (wb && op == 4'h0 && wdata[3:2] == 2'h2
        |=> !chan_out[1].rx_enable) else $error("rx disable missed");
    a_ptr_reset: assert property (wa && op == `UCD_CMD_RST_PTR
        |=> !chan_out[0].mode_reg_pointer) else $error("pointer not reset");
    a_ptr_advance: assert property ((wr_stb || rd_stb) && addr == `UCD_OFS_MODE_A
        |=> chan_out[0].mode_reg_pointer) else $error("pointer not advanced");
    a_ptr_hold: assert property (chan_out[0].mode_reg_pointer && !(wa && op == 4'h1)
        |=> chan_out[0].mode_reg_pointer) else $error("pointer dropped");
    a_rx_reset: assert property (wa && op == `UCD_CMD_RST_RX && wdata[3:0] == 4'h0
        |=> chan_out[0].rx_reset && !chan_out[0].rx_enable) else $error("rx reset wrong");
    a_tx_reset: assert property (wa && op == `UCD_CMD_RST_TX && wdata[3:0] == 4'h0
        |=> chan_out[0].tx_reset && chan_out[0].serial_tx_output && !chan_out[0].tx_enable)
        else $error("tx reset wrong");
    a_brk_clear: assert property (wa && op == `UCD_CMD_RST_BRK && !chan_in[0].brk_chg_ev
        |=> !chan_out[0].brk_chg_pend) else $error("break change kept");
    a_rx_ext_set: assert property (wb && op == `UCD_CMD_RX_EXT_SET
        |=> chan_out[1].rx_ext && $stable(chan_out[0].rx_ext)) else $error("rx extend wrong");
    a_tx_ext_clr: assert property (wa && op == `UCD_CMD_TX_EXT_CLR
        |=> !chan_out[0].tx_ext) else $error("tx extend not cleared");
    a_standby_b: assert property (wb && op == `UCD_CMD_STANDBY
        |=> standby == $past(standby)) else $error("standby through B");
    a_standby_a: assert property (wa && op == `UCD_CMD_STANDBY
        |=> standby ##1 !chan_out[0].tx_enable) else $error("standby wrong");
    c_break: cover property (chan_out[0].tx_enable && !chan_out[0].serial_tx_output);
    c_standby: cover property (standby);
    c_irq: cover property (irq);
endmodule : ucd_checker

bind ucd_top ucd_checker u_ucd_checker (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .chan_in(chan_in), .rdata(rdata),
    .chan_out(chan_out), .standby(standby), .irq(irq));
`default_nettype wire

// ### test/uart_channel_command_decoder_tb_top.sv
// Register port bench of the command decoder.
// Assumes the datapath model serves channel A only.
`timescale 1ns/1ps
`default_nettype none
`include "ucd_defs.svh"

module uart_channel_command_decoder_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [`UCD_AW-1:0] addr = '0;
    logic [`UCD_DW-1:0] wdata = '0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic go = 1'b0;
    ucd_pkg::ucd_chan_in_t [1:0] ci = '0;
    ucd_pkg::ucd_chan_in_t [1:0] chan_in;
    ucd_pkg::ucd_chan_out_t [1:0] chan_out;
    logic [`UCD_DW-1:0] rdata;
    logic standby, irq, tick, empty, ser, p;
    logic [7:0] d;
    logic [4:0] ca [2] = '{`UCD_OFS_CMD_A, `UCD_OFS_CMD_B};
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    always_comb begin
        chan_in = ci;
        chan_in[0].bit_tick = tick;
        chan_in[0].tx_empty_condition = empty;
        chan_in[0].tx_serial = ser;
    end
    ucd_top u_ucd_top (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .chan_in(chan_in), .rdata(rdata),
        .chan_out(chan_out), .standby(standby), .irq(irq));
    ucd_dp_model u_ucd_dp_model (.ref_clk(ref_clk), .rst(rst), .go(go),
        .tx_enable(chan_out[0].tx_enable), .tx_start_ok(chan_out[0].tx_start_ok),
        .bit_tick(tick), .tx_empty_condition(empty), .tx_serial(ser));
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            conclude();
        end
    end
    // ----------------------------------------
    // Bus, check, line-wait and finish tasks
    // ----------------------------------------
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(posedge ref_clk);
        v = rdata;
    endtask : rd
    task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic wait_line(input logic v);
        n = 0;
        while (chan_out[0].serial_tx_output !== v && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_line
    task automatic conclude;
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        ci[1].tx_empty_condition = 1'b1;
        ci[1].tx_serial = 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(`UCD_OFS_CHIP_CTL, d);
        chk("ctl reset", d, 8'h00);
        rd(5'h1F, d);
        chk("unmapped", d, 8'h00);
        for (int c = 0; c < 2; c++) begin
            wr(ca[c], 8'h05);
            chk("tx on", chan_out[c].tx_enable, 1'b1);
            wr(ca[c], 8'h00);
            chk("rx kept", chan_out[c].rx_enable, 1'b1);
            wr(ca[c], 8'h0A);
            chk("tx off", chan_out[c].tx_enable, 1'b0);
            chk("rx off", chan_out[c].rx_enable, 1'b0);
            for (int k = 8; k < 12; k++) begin
                wr(ca[c], 8'(k << 4));
                chk("ext", k[1] ? chan_out[c].tx_ext : chan_out[c].rx_ext, !k[0]);
                chk("ext other", chan_out[1-c].tx_ext | chan_out[1-c].rx_ext, 1'b0);
            end
        end
        wr(ca[0], 8'h05);
        wr(ca[0], 8'h20);
        chk("rx pulse", chan_out[0].rx_reset, 1'b1);
        chk("rx dis", chan_out[0].rx_enable, 1'b0);
        rd(`UCD_OFS_MODE_A, d);
        chk("ptr adv", chan_out[0].mode_reg_pointer, 1'b1);
        wr(`UCD_OFS_MODE_A, 8'h00);
        chk("ptr stays", chan_out[0].mode_reg_pointer, 1'b1);
        wr(ca[0], 8'h10);
        chk("ptr back", chan_out[0].mode_reg_pointer, 1'b0);
        wr(`UCD_OFS_CHIP_CTL, 8'h02);
        ci[0].pe_ev <= 1'b1;
        @(posedge ref_clk);
        ci[0].pe_ev <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(`UCD_OFS_STAT_A, d);
        chk("block pe", d, 8'h28);
        wr(ca[0], 8'h40);
        rd(`UCD_OFS_STAT_A, d);
        chk("err reset", d, 8'h08);
        ci[1].head_fe <= 1'b1;
        ci[1].oe_ev <= 1'b1;
        @(posedge ref_clk);
        ci[1].oe_ev <= 1'b0;
        rd(`UCD_OFS_STAT_B, d);
        chk("char fe", d, 8'h58);
        ci[1].head_fe <= 1'b0;
        @(posedge ref_clk);
        rd(`UCD_OFS_STAT_B, d);
        chk("oe sticky", d, 8'h18);
        wr(ca[1], 8'h40);
        rd(`UCD_OFS_STAT_B, d);
        chk("oe reset", d, 8'h08);
        wr(`UCD_OFS_IRQ_MASK, 8'h01);
        ci[0].brk_chg_ev <= 1'b1;
        @(posedge ref_clk);
        ci[0].brk_chg_ev <= 1'b0;
        rd(`UCD_OFS_IRQ_STAT, d);
        chk("stat", d, 8'h0D);
        chk("irq on", irq, 1'b1);
        chk("pend on", chan_out[0].brk_chg_pend, 1'b1);
        wr(ca[0], 8'h50);
        chk("pend off", chan_out[0].brk_chg_pend, 1'b0);
        wr(`UCD_OFS_IRQ_STAT, 8'h0F);
        rd(`UCD_OFS_IRQ_STAT, d);
        chk("w1c", d, 8'h00);
        chk("irq off", irq, 1'b0);
        wr(ca[0], 8'h60);
        wait_line(1'b0);
        chk("brk start", n <= 9, 1'b1);
        wr(ca[0], 8'h70);
        chk("brk held", chan_out[0].serial_tx_output, 1'b0);
        wait_line(1'b1);
        chk("brk stop", n <= 9, 1'b1);
        n = 0;
        while (chan_out[0].tx_start_ok !== 1'b1 && n < 20) begin
            chk("mark", chan_out[0].serial_tx_output, 1'b1);
            @(posedge ref_clk);
            n++;
        end
        chk("mark len", n >= 3 && n <= 5, 1'b1);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        wr(ca[0], 8'h60);
        p = ser;
        n = 0;
        while (empty !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            n++;
            chk("defer", chan_out[0].serial_tx_output, p);
            p = ser;
        end
        wait_line(1'b0);
        chk("late brk", n <= 9, 1'b1);
        wr(ca[0], 8'h30);
        chk("tx rst", chan_out[0].tx_reset, 1'b1);
        chk("tx line", chan_out[0].serial_tx_output, 1'b1);
        wr(ca[0], 8'h05);
        wr(ca[1], 8'hC0);
        chk("sby b", standby, 1'b0);
        wr(ca[0], 8'hC0);
        @(posedge ref_clk);
        chk("sby a", standby, 1'b1);
        chk("sby tx", chan_out[0].tx_enable, 1'b0);
        wr(ca[0], 8'hD0);
        chk("active", standby, 1'b0);
        conclude();
    end
endmodule : uart_channel_command_decoder_tb_top
`default_nettype wire
